// file: logic/ssm_pkg.sv
/*
  Package for the servo status and monitor display selector: register map,
  reset values, modes and carrier structs.
  Assumes a single AHB-Lite master and one 100 MHz clock.
*/
package ssm_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SEL = 8'h0C;
  localparam logic [7:0] ADDR_VALUE = 8'h10;
  localparam logic [7:0] ADDR_ALARM_BASE = 8'h20;
  localparam int ALARM_DEPTH = 10;
  localparam int MON_LAST = 9;
  localparam int TORQUE_PCT_MIN = 10;
  localparam int PULSE_WINDOW_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_WINDOW_CYC = PULSE_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [15:0] PARAM_INPOS_RST = 16'h0007;
  localparam logic [15:0] PARAM_VBAND_RST = 16'h000A;
  localparam logic [15:0] PARAM_ROT_RST = 16'h0014;
  localparam logic [3:0] MON_RST = 4'h0;

  typedef enum logic [1:0] {MODE_STATUS, MODE_SETTINGS, MODE_MONITOR, MODE_ALARM} ssm_mode_type;
  typedef enum logic [2:0] {SYM_BLOCKED, SYM_RUN, SYM_FWD_INH, SYM_REV_INH, SYM_ALARM} ssm_sym_type;

  typedef struct packed {
    logic mode_key;
    logic up_key;
    logic down_key;
    logic data_key;
  } ssm_keys_type;

  typedef struct packed {
    logic ctrl_pwr;
    logic main_pwr;
    logic servo_on;
    logic fwd_inhibit;
    logic rev_inhibit;
    logic alarm;
    logic [7:0] alarm_code;
    logic pulse_mode;
    logic cmd_pulse;
    logic cmd_pulse_dir;
    logic err_clear;
    logic abs_encoder;
    logic signed [15:0] speed;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] torque_cmd;
    logic [15:0] u_phase_count;
    logic [15:0] elec_angle;
    logic [19:0] status_word1;
    logic [19:0] status_word2;
    logic signed [15:0] pos_error;
    logic [15:0] pulse_to_rpm;
  } ssm_drive_type;

  typedef struct packed {
    logic ctrl_pwr;
    logic main_pwr;
    logic unpowered;
    logic dim;
    logic in_position;
    logic speed_match;
    logic rotating;
    logic cmd_pulse;
    logic speed_cmd;
    logic torque_cmd;
    logic err_clear;
  } ssm_ind_type;
endpackage : ssm_pkg

// file: logic/ssm_display.sv
/*
  Display selection logic: key-driven mode sequencer, status indicators and
  symbol, ten-way monitor selector, alarm history, AHB-Lite register slave.
  Register words: 0x00 mode and history fill, 0x04 in-position window and
  speed-match band, 0x08 indicators and symbol (read only), 0x0C rotation
  threshold and monitor number, 0x10 selected value (read only),
  0x20 onwards the alarm history, newest first.
  The slave answers with no wait states and always reports OKAY.
  Assumes keys are one-cycle pulses synchronous to hclk and all drive inputs
  are synchronous samples of the servo core.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode key steps to next mode
// - Reset starts in status mode, bits and symbol
// - Control and main supply indicator bits
// - Unpowered lit when blocked, dimmed when enabled
// - In-position when error below window
// - Speed match within command plus or minus band
// - Rotating when speed at threshold
// - Command pulse indicator while pulses arrive
// - Speed command reaches rotation threshold
// - Torque command at least ten percent
// - Indicator while error clear input active
// - Symbol: blocked, run, inhibits, alarm code
// - Ten monitors numbered zero to nine
// - Speed; speed command zero in pulse mode
// - Torque command percent of rated
// - Encoder count since U-phase edge
// - Electrical angle in degrees
// - Monitors five, six show status words
// - Command pulse frequency as rpm
// - Position error in command units
// - Running count of input pulses
// - Up/down select, data toggles, mode advances
// - Four modes; ten alarms remembered
module ssm_display #(
  parameter int PULSE_WINDOW = ssm_pkg::PULSE_WINDOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ssm_pkg::ssm_keys_type keys,
  input wire ssm_pkg::ssm_drive_type drive,
  output ssm_pkg::ssm_mode_type mode,
  output ssm_pkg::ssm_ind_type ind,
  output ssm_pkg::ssm_sym_type sym,
  output logic [7:0] sym_alarm,
  output logic [3:0] mon_num,
  output logic show_value,
  output logic [31:0] disp_value
);

  typedef struct packed {
    ssm_pkg::ssm_mode_type mode;
    logic [3:0] mon;
    logic show;
    ssm_pkg::ssm_ind_type ind;
    ssm_pkg::ssm_sym_type sym;
    logic [7:0] sym_alarm;
    logic [31:0] value;
    logic [15:0] inpos;
    logic [15:0] vband;
    logic [15:0] rot;
    logic [31:0] pulse_total;
    logic [31:0] win_cnt;
    logic [15:0] win_pulses;
    logic [15:0] pulse_freq;
    logic [ssm_pkg::ALARM_DEPTH-1:0][7:0] hist;
    logic [3:0] hist_n;
    logic alarm_prev;
    logic [3:0] hist_idx;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
  } ssm_state_type;

  ssm_state_type st_ff;
  ssm_state_type nxt_st;

  // Magnitudes of the signed drive quantities; thresholds are unsigned
  logic [15:0] abs_speed;
  logic [15:0] abs_scmd;
  logic [15:0] abs_tcmd;
  logic [15:0] abs_err;
  logic signed [16:0] spd_diff;
  logic [16:0] abs_sdiff;
  logic hit_err;
  logic hit_band;
  logic hit_rot;
  logic hit_scmd;
  logic hit_tcmd;
  // Speed error one bit wider so a full-scale swing cannot wrap
  assign spd_diff = 17'(drive.speed) - 17'(drive.speed_cmd);

  // Motor speed magnitude
  ssm_mag #(
    .W(16)
  ) u_mag_speed (
    .val(drive.speed),
    .mag(abs_speed)
  );
  // Speed command magnitude
  ssm_mag #(
    .W(16)
  ) u_mag_scmd (
    .val(drive.speed_cmd),
    .mag(abs_scmd)
  );
  // Torque command magnitude, either direction counts
  ssm_mag #(
    .W(16)
  ) u_mag_tcmd (
    .val(drive.torque_cmd),
    .mag(abs_tcmd)
  );
  // Position error magnitude
  ssm_mag #(
    .W(16)
  ) u_mag_err (
    .val(drive.pos_error),
    .mag(abs_err)
  );
  // Speed error magnitude
  ssm_mag #(
    .W(17)
  ) u_mag_sdiff (
    .val(spd_diff),
    .mag(abs_sdiff)
  );

  // Error at or past the window; in-position is its inverse
  ssm_at_least #(
    .W(16)
  ) u_ge_err (
    .a(abs_err),
    .b(st_ff.inpos),
    .hit(hit_err)
  );
  // Band still covers the speed error
  ssm_at_least #(
    .W(17)
  ) u_ge_band (
    .a({1'b0, st_ff.vband}),
    .b(abs_sdiff),
    .hit(hit_band)
  );
  // Motor speed reaches the rotation threshold
  ssm_at_least #(
    .W(16)
  ) u_ge_rot (
    .a(abs_speed),
    .b(st_ff.rot),
    .hit(hit_rot)
  );
  // Speed command reaches the rotation threshold
  ssm_at_least #(
    .W(16)
  ) u_ge_scmd (
    .a(abs_scmd),
    .b(st_ff.rot),
    .hit(hit_scmd)
  );
  // Torque command reaches the minimum percentage
  ssm_at_least #(
    .W(16)
  ) u_ge_tcmd (
    .a(abs_tcmd),
    .b(16'(ssm_pkg::TORQUE_PCT_MIN)),
    .hit(hit_tcmd)
  );


  always_comb begin
    nxt_st = st_ff;
    // Mode sequencer; data toggle only meaningful in monitor mode
    if (keys.mode_key) begin
      nxt_st.show = 1'b0;
      case (st_ff.mode)
        ssm_pkg::MODE_STATUS: nxt_st.mode = ssm_pkg::MODE_SETTINGS;
        ssm_pkg::MODE_SETTINGS: nxt_st.mode = ssm_pkg::MODE_MONITOR;
        ssm_pkg::MODE_MONITOR: nxt_st.mode = ssm_pkg::MODE_ALARM;
        default: nxt_st.mode = ssm_pkg::MODE_STATUS;
      endcase
    end else if (st_ff.mode == ssm_pkg::MODE_MONITOR) begin
      if (keys.data_key) begin
        nxt_st.show = ~st_ff.show;
      end else if (!st_ff.show && keys.up_key) begin
        nxt_st.mon = (st_ff.mon == 4'(ssm_pkg::MON_LAST)) ? 4'h0 : st_ff.mon + 4'h1;
      end else if (!st_ff.show && keys.down_key) begin
        nxt_st.mon = (st_ff.mon == 4'h0) ? 4'(ssm_pkg::MON_LAST) : st_ff.mon - 4'h1;
      end
    end else if (st_ff.mode == ssm_pkg::MODE_ALARM) begin
      if (keys.up_key && st_ff.hist_idx != 4'(ssm_pkg::ALARM_DEPTH - 1)) begin
        nxt_st.hist_idx = st_ff.hist_idx + 4'h1;
      end else if (keys.down_key && st_ff.hist_idx != 4'h0) begin
        nxt_st.hist_idx = st_ff.hist_idx - 4'h1;
      end
    end

    // Status indicator bits
    nxt_st.ind.ctrl_pwr = drive.ctrl_pwr;
    nxt_st.ind.main_pwr = drive.main_pwr;
    nxt_st.ind.unpowered = 1'b1;
    nxt_st.ind.dim = drive.servo_on;
    nxt_st.ind.in_position = !hit_err;
    nxt_st.ind.speed_match = hit_band;
    nxt_st.ind.rotating = hit_rot;
    nxt_st.ind.cmd_pulse = st_ff.win_pulses != 16'h0000 || drive.cmd_pulse;
    nxt_st.ind.speed_cmd = hit_scmd;
    nxt_st.ind.torque_cmd = hit_tcmd;
    nxt_st.ind.err_clear = drive.err_clear;

    // Symbol code, alarm first; an inhibit hides run so the operator
    // sees why the axis is not moving
    nxt_st.sym_alarm = drive.alarm_code;
    if (drive.alarm) begin
      nxt_st.sym = ssm_pkg::SYM_ALARM;
    end else if (drive.fwd_inhibit) begin
      nxt_st.sym = ssm_pkg::SYM_FWD_INH;
    end else if (drive.rev_inhibit) begin
      nxt_st.sym = ssm_pkg::SYM_REV_INH;
    end else if (drive.servo_on) begin
      nxt_st.sym = ssm_pkg::SYM_RUN;
    end else begin
      nxt_st.sym = ssm_pkg::SYM_BLOCKED;
    end

    // Pulse counter and frequency window
    if (drive.cmd_pulse) begin
      nxt_st.pulse_total = drive.cmd_pulse_dir ? st_ff.pulse_total - 32'h1 : st_ff.pulse_total + 32'h1;
    end
    if (st_ff.win_cnt >= 32'(PULSE_WINDOW - 1)) begin
      nxt_st.win_cnt = 32'h0;
      nxt_st.pulse_freq = st_ff.win_pulses + 16'(drive.cmd_pulse);
      nxt_st.win_pulses = 16'h0;
    end else begin
      nxt_st.win_cnt = st_ff.win_cnt + 32'h1;
      if (drive.cmd_pulse && st_ff.win_pulses != 16'hFFFF) begin
        nxt_st.win_pulses = st_ff.win_pulses + 16'h1;
      end
    end

    // Alarm history on rising alarm edge, newest in slot zero
    nxt_st.alarm_prev = drive.alarm;
    if (drive.alarm && !st_ff.alarm_prev) begin
      nxt_st.hist = {st_ff.hist[ssm_pkg::ALARM_DEPTH-2:0], drive.alarm_code};
      if (st_ff.hist_n != 4'(ssm_pkg::ALARM_DEPTH)) begin
        nxt_st.hist_n = st_ff.hist_n + 4'h1;
      end
    end

    // Monitor value mux
    case (st_ff.mon)
      4'h0: nxt_st.value = 32'(drive.speed);
      4'h1: nxt_st.value = drive.pulse_mode ? 32'h0 : 32'(drive.speed_cmd);
      4'h2: nxt_st.value = 32'(drive.torque_cmd);
      4'h3: nxt_st.value = {16'h0, drive.u_phase_count};
      4'h4: nxt_st.value = {16'h0, drive.elec_angle};
      4'h5: nxt_st.value = {12'h0, drive.status_word1};
      4'h6: nxt_st.value = {12'h0, drive.status_word2};
      4'h7: nxt_st.value = 32'(st_ff.pulse_freq) * 32'(drive.pulse_to_rpm);
      4'h8: nxt_st.value = 32'(drive.pos_error);
      4'h9: nxt_st.value = st_ff.pulse_total;
      default: nxt_st.value = 32'h0;
    endcase

    // Alarm mode shows the selected history entry instead
    if (st_ff.mode == ssm_pkg::MODE_ALARM) begin
      nxt_st.value = {24'h0, st_ff.hist[st_ff.hist_idx]};
    end

    // AHB-Lite slave with no wait states. The address phase is latched and
    // the write lands in the data phase, when hwdata is valid; read data is
    // registered at the address edge so it stands through the data phase.
    // A bus write to the mode word overrides a key press in the same cycle.
    if (st_ff.dph && st_ff.dwr) begin
      if (st_ff.daddr == ssm_pkg::ADDR_CTRL) begin
        nxt_st.mode = ssm_pkg::ssm_mode_type'(hwdata[1:0]);
      end else if (st_ff.daddr == ssm_pkg::ADDR_PARAM) begin
        nxt_st.inpos = hwdata[15:0];
        nxt_st.vband = {8'h00, hwdata[23:16]};
      end else if (st_ff.daddr == ssm_pkg::ADDR_SEL) begin
        nxt_st.rot = hwdata[15:0];
        if (hwdata[19:16] <= 4'(ssm_pkg::MON_LAST)) begin
          nxt_st.mon = hwdata[19:16];
        end
      end
    end
    nxt_st.dph = hsel && htrans[1] && hready;
    nxt_st.dwr = hwrite;
    nxt_st.daddr = haddr[7:0];
    nxt_st.rdata = 32'h0;
    // Bus answer flags are registered so the outputs come from flops
    nxt_st.rdy = 1'b1;
    nxt_st.resp = 1'b0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[7:0] == ssm_pkg::ADDR_CTRL) begin
        nxt_st.rdata = {24'h0, st_ff.hist_n, st_ff.show, 1'b0, st_ff.mode};
      end else if (haddr[7:0] == ssm_pkg::ADDR_PARAM) begin
        nxt_st.rdata = {8'h0, st_ff.vband[7:0], st_ff.inpos};
      end else if (haddr[7:0] == ssm_pkg::ADDR_STATUS) begin
        nxt_st.rdata = {5'h0, st_ff.sym, st_ff.sym_alarm, 5'h0, st_ff.ind};
      end else if (haddr[7:0] == ssm_pkg::ADDR_SEL) begin
        nxt_st.rdata = {12'h0, st_ff.mon, st_ff.rot};
      end else if (haddr[7:0] == ssm_pkg::ADDR_VALUE) begin
        nxt_st.rdata = st_ff.value;
      end else if (haddr[7:0] >= ssm_pkg::ADDR_ALARM_BASE &&
                   haddr[7:0] < ssm_pkg::ADDR_ALARM_BASE + 8'(ssm_pkg::ALARM_DEPTH * 4)) begin
        nxt_st.rdata = {24'h0, st_ff.hist[4'(haddr[5:2] - 4'h8)]};
      end
    end
  end

  // State register; reset lands in status mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.mode <= ssm_pkg::MODE_STATUS;
      st_ff.mon <= ssm_pkg::MON_RST;
      st_ff.inpos <= ssm_pkg::PARAM_INPOS_RST;
      st_ff.vband <= ssm_pkg::PARAM_VBAND_RST;
      st_ff.rot <= ssm_pkg::PARAM_ROT_RST;
      st_ff.ind.unpowered <= 1'b1;
      st_ff.rdy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.rdata;
  assign hreadyout = st_ff.rdy;
  assign hresp = st_ff.resp;
  assign mode = st_ff.mode;
  assign ind = st_ff.ind;
  assign sym = st_ff.sym;
  assign sym_alarm = st_ff.sym_alarm;
  assign mon_num = st_ff.mon;
  assign show_value = st_ff.show;
  assign disp_value = st_ff.value;

endmodule : ssm_display

// Magnitude of a two's complement value
module ssm_mag #(
  parameter int W = 16
) (
  input wire logic signed [W-1:0] val,
  output logic [W-1:0] mag
);
  // The most negative value has no positive twin and maps to itself
  assign mag = val[W-1] ? W'(-val) : W'(val);
endmodule : ssm_mag

// Unsigned at-least compare shared by the indicator thresholds
module ssm_at_least #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic hit
);
  // High when a reaches b
  assign hit = a >= b;
endmodule : ssm_at_least
`default_nettype wire

// file: testbench/ssm_display_assertions.sv
/*
  Checker for the display selector: indicators, symbol, mode keys, bus.
  Assumes binding to ssm_display and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ssm_display_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ssm_pkg::ssm_keys_type keys,
  input wire ssm_pkg::ssm_drive_type drive,
  input wire ssm_pkg::ssm_mode_type mode,
  input wire ssm_pkg::ssm_ind_type ind,
  input wire ssm_pkg::ssm_sym_type sym,
  input wire logic [7:0] sym_alarm,
  input wire logic [3:0] mon_num,
  input wire logic show_value
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Indicators follow the drive one cycle later
  a_pwr_bits: assert property ($past(hresetn) |-> {ind.ctrl_pwr, ind.main_pwr} == $past({drive.ctrl_pwr, drive.main_pwr}))
    else $error("supply bits wrong");
  a_dim_follows: assert property ($past(hresetn) |-> ind.unpowered && ind.dim == $past(drive.servo_on))
    else $error("unpowered bit wrong");
  a_torque_ind: assert property ($past(hresetn) |-> ind.torque_cmd == ($past(drive.torque_cmd) >= 16'sh000A || $past(drive.torque_cmd) <= 16'shFFF6))
    else $error("torque bit wrong");
  a_clear_ind: assert property ($past(hresetn) |-> ind.err_clear == $past(drive.err_clear))
    else $error("clear bit wrong");
  a_alarm_sym: assert property ($past(hresetn) && $past(drive.alarm) |-> sym == ssm_pkg::SYM_ALARM && sym_alarm == $past(drive.alarm_code))
    else $error("alarm symbol wrong");
  // Key sequencing, monitor range and bus answer
  a_mode_step: assert property (keys.mode_key |=> mode == ssm_pkg::ssm_mode_type'($past(mode) + 2'h1))
    else $error("mode did not step");
  a_key_hides: assert property (keys.mode_key |=> !show_value)
    else $error("show not cleared");
  a_data_toggle: assert property (mode == ssm_pkg::MODE_MONITOR && keys.data_key |=> show_value != $past(show_value))
    else $error("data key no toggle");
  a_mon_range: assert property (mon_num <= 4'h9)
    else $error("monitor number out of range");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule : ssm_display_checker
bind ssm_display ssm_display_checker chk (.*);
`default_nettype wire

// file: testbench/ssm_keypad_model.sv
/*
  Keypad model: a person pressing one key at a time.
  Assumes the bench calls press with a key bit index (3 mode .. 0 data).
*/
`timescale 1ns/1ps
`default_nettype none
module ssm_keypad_model (
  input wire logic hclk,
  output var ssm_pkg::ssm_keys_type keys
);
  initial keys = '0;
  // One-cycle pulse, then a release gap before the next key
  task automatic press(input int k);
    @(posedge hclk);
    keys[k] <= 1'b1;
    @(posedge hclk);
    keys <= '0;
    repeat (3) @(posedge hclk);
  endtask : press
endmodule : ssm_keypad_model
`default_nettype wire

// file: testbench/tb_top.sv
/*
  Self-checking bench for the display selector.
  Assumes the keypad model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, show_value;
  logic [31:0] haddr, hwdata, hrdata, disp_value, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] sym_alarm;
  logic [3:0] mon_num;
  logic [31:0] ev [10];
  ssm_pkg::ssm_keys_type keys;
  ssm_pkg::ssm_drive_type drive;
  ssm_pkg::ssm_mode_type mode;
  ssm_pkg::ssm_ind_type ind;
  ssm_pkg::ssm_sym_type sym;
  int fail_count = 0;
  int checks_done = 0;
  ssm_keypad_model kp (.hclk(hclk), .keys(keys));
  ssm_display #(.PULSE_WINDOW(16)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .keys(keys), .drive(drive), .mode(mode), .ind(ind), .sym(sym),
    .sym_alarm(sym_alarm), .mon_num(mon_num), .show_value(show_value), .disp_value(disp_value));
  // Clock at 100 MHz
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // One AHB-Lite single word transfer
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : xfer
  task settle;
    repeat (2) @(posedge hclk);
  endtask : settle
  // Reset state, unmapped accesses
  task t_reset;
    `CHK(mode, ssm_pkg::MODE_STATUS)
    `CHK(sym, ssm_pkg::SYM_BLOCKED)
    `CHK(ind, 11'h100)
    xfer(1'b1, 8'h80, 32'hFFFFFFFF);
    xfer(1'b0, 8'h80, 32'h0);
    `CHK(d, 32'h0)
    xfer(1'b0, ssm_pkg::ADDR_CTRL, 32'h0);
    `CHK(d[1:0], 2'h0)
  endtask : t_reset
  // Indicator thresholds at their edges, symbol priority
  task t_status;
    @(posedge hclk);
    {drive.ctrl_pwr, drive.main_pwr, drive.servo_on, drive.err_clear} <= 4'hF;
    {drive.pos_error, drive.speed, drive.speed_cmd, drive.torque_cmd} <= 64'h0006_0014_001E_000A;
    settle();
    `CHK(ind, 11'h7F7)
    `CHK(sym, ssm_pkg::SYM_RUN)
    {drive.servo_on, drive.err_clear, drive.rev_inhibit} <= 3'h1;
    {drive.pos_error, drive.speed, drive.speed_cmd, drive.torque_cmd} <= 64'h0007_0013_001E_0009;
    settle();
    `CHK(ind, 11'h704)
    `CHK(sym, ssm_pkg::SYM_REV_INH)
    drive.fwd_inhibit <= 1'b1;
    settle();
    `CHK(sym, ssm_pkg::SYM_FWD_INH)
    {drive.alarm, drive.alarm_code} <= 9'h15A;
    settle();
    `CHK(sym_alarm, 8'h5A)
    `CHK(sym, ssm_pkg::SYM_ALARM)
    xfer(1'b1, ssm_pkg::ADDR_PARAM, 32'h000A0003);
    drive.pos_error <= 16'sh0003;
    settle();
    `CHK(ind.in_position, 1'b0)
  endtask : t_status
  // Mode walk and the ten monitors
  task t_monitor;
    ev = '{32'h4D2, 32'h0, 32'h37, 32'h1000, 32'h5A, 32'hA5A5A, 32'hC3, 32'h0, 32'h21, 32'h5};
    {drive.speed, drive.speed_cmd, drive.torque_cmd, drive.u_phase_count} <= 64'h04D2_00C8_0037_1000;
    {drive.elec_angle, drive.status_word1, drive.status_word2, drive.pos_error} <= 72'h005A_A5A5A_000C3_0021;
    drive.pulse_mode <= 1'b1;
    drive.pulse_to_rpm <= 16'h0003;
    repeat (5) begin
      @(posedge hclk);
      drive.cmd_pulse <= 1'b1;
      @(posedge hclk);
      drive.cmd_pulse <= 1'b0;
    end
    kp.press(3);
    `CHK(mode, ssm_pkg::MODE_SETTINGS)
    kp.press(3);
    `CHK(mode, ssm_pkg::MODE_MONITOR)
    kp.press(1);
    `CHK(mon_num, 4'h9)
    kp.press(2);
    for (int i = 0; i < 10; i++) begin
      if (i != 7) begin
        kp.press(0);
        `CHK(disp_value, ev[i])
        kp.press(0);
        `CHK(show_value, 1'b0)
      end
      kp.press(2);
    end
    `CHK(mon_num, 4'h0)
    // Steady reverse pulses: 8 per 16-cycle window, times 3 rpm per pulse
    xfer(1'b1, ssm_pkg::ADDR_SEL, 32'h00070014);
    drive.cmd_pulse_dir <= 1'b1;
    fork
      repeat (24) begin
        @(posedge hclk);
        drive.cmd_pulse <= 1'b1;
        @(posedge hclk);
        drive.cmd_pulse <= 1'b0;
      end
      begin
        repeat (40) @(posedge hclk);
        `CHK(ind.cmd_pulse, 1'b1)
        xfer(1'b0, ssm_pkg::ADDR_VALUE, 32'h0);
        `CHK(d, 32'h00000018)
      end
    join
    xfer(1'b1, ssm_pkg::ADDR_SEL, 32'h00090014);
    xfer(1'b0, ssm_pkg::ADDR_VALUE, 32'h0);
    `CHK(d, 32'hFFFFFFED)
    xfer(1'b0, ssm_pkg::ADDR_CTRL, 32'h0);
    `CHK(d[1:0], 2'h2)
    kp.press(3);
    `CHK(mode, ssm_pkg::MODE_ALARM)
    `CHK(disp_value, 32'h0000005A)
    kp.press(3);
    `CHK(mode, ssm_pkg::MODE_STATUS)
  endtask : t_monitor
  task summarize;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // Cuts a hang short
  initial begin
    repeat (4000) @(posedge hclk);
    fail_count++;
    summarize();
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, drive} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_status();
    t_monitor();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
